/* logic/ipw_params.svh */
// constants of the interrupt priority and wake-up map
// included by the package and the map module
`ifndef IPW_PARAMS_SVH
`define IPW_PARAMS_SVH
`define IPW_NUM_IRQ 89
`define IPW_NUM_EXC 105
`define IPW_EXC_NMI 7'h02
`define IPW_EXC_HARD 7'h03
`define IPW_EXC_MEM 7'h04
`define IPW_EXC_BUS 7'h05
`define IPW_EXC_USAGE 7'h06
`define IPW_EXC_SVC 7'h0b
`define IPW_EXC_DEBUG 7'h0c
`define IPW_EXC_PENDSVC 7'h0e
`define IPW_EXC_TICK 7'h0f
`define IPW_EXC_IRQ0 7'h10
`define IPW_EXC_LAST 7'h68
`define IPW_KEY_HARD 4'h2
`define IPW_KEY_PROG_BASE 4'h3
`define IPW_KEY_NONE 4'hf
`define IPW_PRIO_RST 3'h0
`define IPW_MODE_ACTIVE 2'h0
`define IPW_MODE_CORE_SLEEP 2'h1
`define IPW_MODE_SYS_SLEEP 2'h2
`define IPW_MODE_HIBERNATE 2'h3
`define IPW_PERIPH_REGION 3'h2
`define IPW_DEEP_WAKE_MASK 89'h0fff
`define IPW_CORE_WAKE_MASK 89'h1_ffff_ffff_ffff_ffff_ff
`endif

/* logic/ipw_pkg.sv */
// types of the interrupt priority and wake-up map
// assumes ipw_params.svh is on the include path
`include "ipw_params.svh"
package ipw_pkg;
  typedef logic [2:0] ipw_prio_t;
  typedef logic [3:0] ipw_key_t;
  typedef logic [6:0] ipw_exc_t;
  typedef logic [1:0] ipw_mode_t;
  typedef logic [`IPW_NUM_IRQ-1:0] ipw_lines_t;
endpackage

/* logic/ipw_map.sv */
// exception ranking, priority store and low-power wake decision
// assumes all sources are synchronous to clk; core acks the winner
`timescale 1ns/1ns
`include "ipw_params.svh"

// How it works
// - exception 2 has no source and is never raised
// - a fault with its handler disabled escalates to hard fault, number 3
// - programmable level 0 ranks below reset, nmi and hard fault
// - bus faults raise exception 5
// - undefined instruction or invalid state raises exception 6
// - misaligned word access to peripherals is rejected as usage fault
// - supervisor call raises 11, pended service request raises 14
// - lines 0 to 72 wake from core sleep; gpio lines 87 and 88 do not
// - only lines 0 to 11 wake from system sleep or hibernate
// - any wake returns the mode to active
// - inside a handler only more urgent lines may wake
// - each priority is three bits, eight levels
// - all priorities read level 0 after reset
// - equal priority goes to the lower number
// - lines 41 to 63 are dma channel done, line 40 dma error
// - timer lines 12 to 16 wake from core sleep only
// - mode field 00 active, 01 core, 10 system, 11 hibernate
module ipw_map (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wake_timer_irq,
  input wire logic [9:0] ext_irq,
  input wire logic watchdog_irq,
  input wire logic [4:0] general_timer_irq,
  input wire logic [22:0] periph_irq,
  input wire logic dma_error_irq,
  input wire logic [22:0] dma_done_irq,
  input wire logic [8:0] analog_irq,
  input wire logic [1:0] gpio_irq,
  input wire ipw_pkg::ipw_lines_t irq_enable,
  input wire logic mem_fault_evt,
  input wire logic bus_fault_evt,
  input wire logic undef_instr_evt,
  input wire logic invalid_state_evt,
  input wire logic svc_instr_evt,
  input wire logic debug_evt,
  input wire logic pend_service_set,
  input wire logic tick_evt,
  input wire logic mem_fault_en,
  input wire logic bus_fault_en,
  input wire logic usage_fault_en,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic acc_word,
  output logic acc_reject,
  input wire logic handler_active,
  input wire ipw_pkg::ipw_prio_t active_prio,
  input wire logic prio_wr,
  input wire ipw_pkg::ipw_exc_t prio_idx,
  input wire ipw_pkg::ipw_prio_t prio_wdata,
  output ipw_pkg::ipw_prio_t prio_rdata,
  input wire logic mode_wr,
  input wire ipw_pkg::ipw_mode_t mode_wdata,
  output ipw_pkg::ipw_mode_t power_mode_field,
  output logic wake_req,
  output logic exc_valid,
  output ipw_pkg::ipw_exc_t exc_num,
  output ipw_pkg::ipw_key_t exc_rank,
  input wire logic exc_ack
);

  function automatic logic is_prog(input ipw_pkg::ipw_exc_t n);
    is_prog = (n >= `IPW_EXC_MEM && n <= `IPW_EXC_USAGE) ||
      (n >= `IPW_EXC_SVC && n <= `IPW_EXC_DEBUG) || n == `IPW_EXC_PENDSVC ||
      (n >= `IPW_EXC_TICK && n <= `IPW_EXC_LAST);
  endfunction

  // lower value is more urgent; fixed ones sit ahead of level 0
  function automatic ipw_pkg::ipw_key_t key_of(input ipw_pkg::ipw_exc_t n,
                                               input ipw_pkg::ipw_prio_t p);
    if (n == `IPW_EXC_HARD) begin
      key_of = `IPW_KEY_HARD;
    end else begin
      key_of = `IPW_KEY_PROG_BASE + {1'b0, p};
    end
  endfunction

  function automatic logic prio_ok(input logic act, input ipw_pkg::ipw_prio_t a,
                                   input ipw_pkg::ipw_prio_t p);
    prio_ok = !act || (p < a);
  endfunction

  ipw_pkg::ipw_lines_t line;
  ipw_pkg::ipw_lines_t qual;
  ipw_pkg::ipw_prio_t prio [0:`IPW_NUM_EXC-1];
  ipw_pkg::ipw_prio_t next_prio [0:`IPW_NUM_EXC-1];
  ipw_pkg::ipw_prio_t next_prio_rdata;
  logic [15:0] pend;
  logic [15:0] next_pend;
  ipw_pkg::ipw_mode_t next_mode;
  logic next_exc_valid;
  ipw_pkg::ipw_exc_t next_exc_num;
  ipw_pkg::ipw_key_t next_exc_rank;
  logic usage_evt;
  logic set_hard;
  logic wake_core;
  logic wake_deep;

  // reserved lines 73..86 have no source
  assign line = {gpio_irq, 14'h0, analog_irq, dma_done_irq, dma_error_irq,
                 periph_irq, general_timer_irq, watchdog_irq, ext_irq, wake_timer_irq};

  assign acc_reject = acc_valid && acc_word &&
    acc_addr[31:29] == `IPW_PERIPH_REGION && acc_addr[1:0] != 2'h0;
  assign usage_evt = undef_instr_evt || invalid_state_evt || acc_reject;
  assign set_hard = (mem_fault_evt && !mem_fault_en) ||
    (bus_fault_evt && !bus_fault_en) || (usage_evt && !usage_fault_en);

  genvar gi;
  generate
    for (gi = 0; gi < `IPW_NUM_IRQ; gi++) begin : g_qual
      assign qual[gi] = line[gi] && irq_enable[gi] &&
        prio_ok(handler_active, active_prio, prio[gi + 16]);
    end
  endgenerate

  // no clock in the path: mode register is retained, lines are levels
  assign wake_core = |(qual & `IPW_CORE_WAKE_MASK);
  assign wake_deep = |(qual & `IPW_DEEP_WAKE_MASK);
  assign wake_req = (power_mode_field == `IPW_MODE_CORE_SLEEP && wake_core) ||
    (power_mode_field[1] && wake_deep);

  always_comb begin
    for (int i = 0; i < `IPW_NUM_EXC; i++) begin
      next_prio[i] = prio[i];
    end
    if (prio_wr && is_prog(prio_idx)) begin
      next_prio[prio_idx] = prio_wdata;
    end
    next_prio_rdata = is_prog(prio_idx) ? prio[prio_idx] : `IPW_PRIO_RST;
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < `IPW_NUM_EXC; i++) begin
      prio[i] <= sys_rst ? `IPW_PRIO_RST : next_prio[i];
    end
    prio_rdata <= sys_rst ? `IPW_PRIO_RST : next_prio_rdata;
  end

  // set wins over an ack of the same exception
  always_comb begin
    next_pend = pend;
    if (exc_ack && exc_valid && exc_num < `IPW_EXC_IRQ0) begin
      next_pend[exc_num[3:0]] = 1'b0;
    end
    next_pend[3] = next_pend[3] | set_hard;
    next_pend[4] = next_pend[4] | (mem_fault_evt && mem_fault_en);
    next_pend[5] = next_pend[5] | (bus_fault_evt && bus_fault_en);
    next_pend[6] = next_pend[6] | (usage_evt && usage_fault_en);
    next_pend[11] = next_pend[11] | svc_instr_evt;
    next_pend[12] = next_pend[12] | debug_evt;
    next_pend[14] = next_pend[14] | pend_service_set;
    next_pend[15] = next_pend[15] | tick_evt;
    next_pend[2] = 1'b0;
    next_pend[1:0] = 2'h0;
    next_pend[10:7] = 4'h0;
    next_pend[13] = 1'b0;
  end

  // ascending scan with strict compare keeps the lower number on ties
  always_comb begin
    next_exc_valid = 1'b0;
    next_exc_num = 7'h00;
    next_exc_rank = `IPW_KEY_NONE;
    for (int i = 3; i < 16; i++) begin
      if (pend[i] && key_of(7'(i), prio[i]) < next_exc_rank) begin
        next_exc_valid = 1'b1;
        next_exc_num = 7'(i);
        next_exc_rank = key_of(7'(i), prio[i]);
      end
    end
    for (int n = 0; n < `IPW_NUM_IRQ; n++) begin
      if (line[n] && irq_enable[n] &&
          key_of(7'(n + 16), prio[n + 16]) < next_exc_rank) begin
        next_exc_valid = 1'b1;
        next_exc_num = 7'(n + 16);
        next_exc_rank = key_of(7'(n + 16), prio[n + 16]);
      end
    end
  end

  always_comb begin
    next_mode = power_mode_field;
    if (power_mode_field != `IPW_MODE_ACTIVE && wake_req) begin
      next_mode = `IPW_MODE_ACTIVE;
    end else if (mode_wr) begin
      next_mode = mode_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pend <= 16'h0000;
      power_mode_field <= `IPW_MODE_ACTIVE;
      exc_valid <= 1'b0;
      exc_num <= 7'h00;
      exc_rank <= `IPW_KEY_NONE;
    end else begin
      pend <= next_pend;
      power_mode_field <= next_mode;
      exc_valid <= next_exc_valid;
      exc_num <= next_exc_num;
      exc_rank <= next_exc_rank;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence s_mem_escalate;
    mem_fault_evt && !mem_fault_en;
  endsequence
  sequence s_hard_wins;
    exc_valid && exc_num == `IPW_EXC_HARD && exc_rank == `IPW_KEY_HARD;
  endsequence

  property p_nmi_never;
    exc_valid |-> exc_num != `IPW_EXC_NMI;
  endproperty
  a_nmi_never: assert property (p_nmi_never) else $error("nmi raised");

  property p_escalate;
    s_mem_escalate |=> pend[3] ##1 s_hard_wins;
  endproperty
  a_escalate: assert property (p_escalate) else $error("no escalation");

  property p_hard_first;
    pend[3] |=> s_hard_wins;
  endproperty
  a_hard_first: assert property (p_hard_first) else $error("hard not first");

  property p_bus_fault;
    bus_fault_evt && bus_fault_en |=> pend[5];
  endproperty
  a_bus_fault: assert property (p_bus_fault) else $error("bus fault lost");

  property p_undef;
    undef_instr_evt && usage_fault_en |=> pend[6];
  endproperty
  a_undef: assert property (p_undef) else $error("usage fault lost");

  property p_unaligned;
    acc_valid && acc_word && acc_addr[31:29] == `IPW_PERIPH_REGION &&
      acc_addr[0] && usage_fault_en |-> acc_reject ##1 pend[6];
  endproperty
  a_unaligned: assert property (p_unaligned) else $error("unaligned taken");

  property p_sram_ok;
    acc_addr[31:29] != `IPW_PERIPH_REGION |-> !acc_reject;
  endproperty
  a_sram_ok: assert property (p_sram_ok) else $error("sram rejected");

  property p_svc;
    svc_instr_evt |=> pend[11];
  endproperty
  a_svc: assert property (p_svc) else $error("svc lost");

  property p_core_wake;
    power_mode_field == `IPW_MODE_CORE_SLEEP && line[12] && irq_enable[12] &&
      !handler_active |-> wake_req ##1 power_mode_field == `IPW_MODE_ACTIVE;
  endproperty
  a_core_wake: assert property (p_core_wake) else $error("no core wake");

  property p_deep_mask;
    power_mode_field[1] && wake_req |-> |(line[11:0] & irq_enable[11:0]);
  endproperty
  a_deep_mask: assert property (p_deep_mask) else $error("bad deep wake");

  property p_return;
    power_mode_field != `IPW_MODE_ACTIVE && wake_req |=>
      power_mode_field == `IPW_MODE_ACTIVE;
  endproperty
  a_return: assert property (p_return) else $error("no return");

  property p_gate;
    handler_active && active_prio == `IPW_PRIO_RST |-> !wake_req;
  endproperty
  a_gate: assert property (p_gate) else $error("wake not gated");

  property p_mode_rw;
    mode_wr && !wake_req |=> power_mode_field == $past(mode_wdata);
  endproperty
  a_mode_rw: assert property (p_mode_rw) else $error("mode lost");

  // first edge after reset release sees the cleared state
  property p_rst_clean;
    $past(sys_rst) |-> prio_rdata == `IPW_PRIO_RST && exc_rank == `IPW_KEY_NONE &&
      power_mode_field == `IPW_MODE_ACTIVE;
  endproperty
  a_rst_clean: assert property (p_rst_clean) else $error("reset state wrong");

  // write, then the index held one more cycle
  sequence s_prio_written;
    prio_wr && is_prog(prio_idx) ##1 !prio_wr && $stable(prio_idx);
  endsequence

  property p_prio_rd;
    s_prio_written |=> prio_rdata == $past(prio_wdata, 2);
  endproperty
  a_prio_rd: assert property (p_prio_rd) else $error("priority not kept");

  property p_timer_shallow;
    power_mode_field[1] && general_timer_irq != 5'h00 &&
      !(|(line[11:0] & irq_enable[11:0])) |-> !wake_req;
  endproperty
  a_timer_shallow: assert property (p_timer_shallow) else $error("timer woke deep");

endmodule

/* test/ipw_core_model.sv */
// core-side partner: takes each registered winner by pulsing the ack
// assumes its inputs settle before the falling edge of clk
`timescale 1ns/1ns
module ipw_core_model (
  input wire logic clk,
  input wire logic ack_en,
  input wire logic exc_valid,
  input wire ipw_pkg::ipw_exc_t exc_num,
  output logic exc_ack,
  output ipw_pkg::ipw_exc_t taken
);
  initial begin
    exc_ack = 1'b0;
    taken = 7'h00;
  end
  // ack lands on the falling edge, like all other stimulus
  always @(negedge clk) begin
    exc_ack <= ack_en && exc_valid;
    if (ack_en && exc_valid) begin
      taken <= exc_num;
    end
  end
endmodule

/* test/interrupt_priority_wakeup_map_tb.sv */
// bench for the priority and wake-up map, with a core partner model
// assumes ipw_pkg is compiled first; stimulus changes on falling edges
`timescale 1ns/1ns
module interrupt_priority_wakeup_map_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [88:0] ln = '0;
  logic [88:0] en = '1;
  logic [7:0] ev = 8'h00;
  logic [2:0] fen = 3'h7;
  logic av = 1'b0, aw = 1'b0, hact = 1'b0, pwr = 1'b0, mwr = 1'b0, ack_en = 1'b1;
  logic [31:0] aadr = 32'h00000000;
  logic [2:0] aprio = 3'h0, pwd = 3'h0;
  logic [6:0] pidx = 7'h00;
  logic [1:0] mwd = 2'h0;
  logic rej, wake, vld, ack;
  ipw_pkg::ipw_prio_t prd;
  ipw_pkg::ipw_mode_t pm;
  ipw_pkg::ipw_exc_t num;
  ipw_pkg::ipw_key_t rank;
  int mismatches = 0;
  int checks = 0;
  int mprio [105];
  int se [8] = '{4, 5, 6, 6, 11, 12, 14, 15};
  logic [95:0] r;

  ipw_map ipw_map_inst (.clk(clk), .sys_rst(sys_rst), .wake_timer_irq(ln[0]),
    .ext_irq(ln[10:1]), .watchdog_irq(ln[11]), .general_timer_irq(ln[16:12]),
    .periph_irq(ln[39:17]), .dma_error_irq(ln[40]), .dma_done_irq(ln[63:41]),
    .analog_irq(ln[72:64]), .gpio_irq(ln[88:87]), .irq_enable(en),
    .mem_fault_evt(ev[0]), .bus_fault_evt(ev[1]), .undef_instr_evt(ev[2]),
    .invalid_state_evt(ev[3]), .svc_instr_evt(ev[4]), .debug_evt(ev[5]),
    .pend_service_set(ev[6]), .tick_evt(ev[7]), .mem_fault_en(fen[0]),
    .bus_fault_en(fen[1]), .usage_fault_en(fen[2]), .acc_valid(av), .acc_addr(aadr),
    .acc_word(aw), .acc_reject(rej), .handler_active(hact), .active_prio(aprio),
    .prio_wr(pwr), .prio_idx(pidx), .prio_wdata(pwd), .prio_rdata(prd), .mode_wr(mwr),
    .mode_wdata(mwd), .power_mode_field(pm), .wake_req(wake), .exc_valid(vld),
    .exc_num(num), .exc_rank(rank), .exc_ack(ack));
  ipw_core_model ipw_core_model_inst (.clk(clk), .ack_en(ack_en), .exc_valid(vld),
    .exc_num(num), .exc_ack(ack), .taken());

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic close_out();
    $display("counts: checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic set_prio(input int idx, input int v);
    pwr = 1'b1;
    pidx = idx[6:0];
    pwd = v[2:0];
    cyc(1);
    pwr = 1'b0;
    if (idx inside {4, 5, 6, 11, 12, 14, 15} || idx >= 16) mprio[idx] = v;
    cyc(1);
    chk(prd, mprio[idx]);
  endtask

  task automatic chk_win();
    int w = -1;
    cyc(1);
    for (int n = 0; n < 89; n++) begin
      if (ln[n] && en[n] && (n < 73 || n > 86) && (w < 0 || mprio[16 + n] < mprio[16 + w])) w = n;
    end
    chk(vld, w >= 0);
    if (w >= 0) begin
      chk(num, 16 + w);
      chk(rank, 3 + mprio[16 + w]);
    end
  endtask

  task automatic sys_evt(input int b, input int exp);
    ev[b] = 1'b1;
    cyc(1);
    ev[b] = 1'b0;
    cyc(1);
    chk(num, exp);
    chk(rank, (exp == 3) ? 2 : 3);
    cyc(4);
  endtask

  task automatic wake_try(input int mode, input int n);
    bit w;
    mwr = 1'b1;
    mwd = mode[1:0];
    cyc(1);
    mwr = 1'b0;
    chk(pm, mode);
    w = en[n] && n <= ((mode == 1) ? 72 : 11) && (!hact || mprio[16 + n] < aprio);
    ln[n] = 1'b1;
    #2;
    chk(wake, w);
    cyc(1);
    chk(pm, w ? 0 : mode);
    ln[n] = 1'b0;
    cyc(1);
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    close_out();
  end

  initial begin
    void'($urandom(32'hd2697a69));
    cyc(16);
    sys_rst = 1'b0;
    chk({vld, rank, pm}, 32'h3c);
    for (int i = 0; i < 105; i += 13) begin
      pidx = i[6:0];
      cyc(2);
      chk(prd, 0);
    end
    $display("reset test done");
    ln[0] = 1'b1;
    for (int f = 0; f < 2; f++) begin
      fen = f ? 3'h0 : 3'h7;
      for (int b = 0; b < 8; b++) sys_evt(b, (f && b < 4) ? 3 : se[b]);
    end
    ln[0] = 1'b0;
    fen = 3'h7;
    {av, aw, aadr} = {2'b11, 32'h40064001};
    #2;
    chk(rej, 1);
    cyc(1);
    aadr = 32'h20001001;
    #2;
    chk(rej, 0);
    cyc(1);
    chk(num, 6);
    {aw, aadr} = {1'b0, 32'h40064001};
    #2;
    chk(rej, 0);
    cyc(1);
    av = 1'b0;
    cyc(4);
    $display("system exception test done");
    foreach (se[i]) set_prio(i * 3 + 1, $urandom_range(7, 0));
    for (int t = 0; t < 12; t++) begin
      set_prio(16 + $urandom_range(88, 0), $urandom_range(7, 0));
      r = {$urandom(), $urandom(), $urandom()};
      ln = r[88:0];
      r = {$urandom(), $urandom(), $urandom()};
      en = r[88:0];
      chk_win();
    end
    {ln, en} = {89'h0, {89{1'b1}}};
    set_prio(35, 5);
    set_prio(36, 5);
    {ln[19], ln[20]} = 2'b11;
    chk_win();
    set_prio(36, 4);
    chk_win();
    ln = '0;
    $display("arbitration test done");
    for (int m = 1; m < 4; m++) begin
      foreach (se[i]) wake_try(m, (i < 7) ? i * 9 + 3 : 11);
    end
    en[5] = 1'b0;
    wake_try(2, 5);
    {hact, aprio} = {1'b1, 3'h3};
    set_prio(35, 2);
    wake_try(1, 19);
    set_prio(35, 3);
    wake_try(1, 19);
    aprio = 3'h0;
    wake_try(1, 19);
    $display("wake test done");
    sys_rst = 1'b1;
    pidx = 7'h23;
    cyc(2);
    sys_rst = 1'b0;
    foreach (mprio[i]) mprio[i] = 0;
    chk(pm, 0);
    cyc(1);
    chk(prd, mprio[35]);
    $display("mid-run reset test done");
    close_out();
  end
endmodule
